// [src/sdmrf_pkg.sv]
package sdmrf_pkg;
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned INIT_MAX_US     = 10;
  localparam int unsigned INIT_MAX_CYCLES = INIT_MAX_US * 1000000 / CLK_PERIOD_PS;
  localparam int unsigned READ_LATENCY    = 3;

  localparam logic [7:0] ADDR_DEV_INFO   = 8'h00;
  localparam logic [7:0] ADDR_FEAT_ONE   = 8'h01;
  localparam logic [7:0] ADDR_FEAT_TWO   = 8'h02;
  localparam logic [7:0] ADDR_IO_CFG     = 8'h03;
  localparam logic [7:0] ADDR_REFRESH    = 8'h04;
  localparam logic [7:0] ADDR_MAKER      = 8'h05;
  localparam logic [7:0] ADDR_REV_ONE    = 8'h06;
  localparam logic [7:0] ADDR_REV_TWO    = 8'h07;
  localparam logic [7:0] ADDR_WDT        = 8'h08;
  localparam logic [7:0] ADDR_TEST_MODE  = 8'h09;
  localparam logic [7:0] ADDR_IO_CAL     = 8'h0a;
  localparam logic [7:0] ADDR_PASR_BANK  = 8'h10;
  localparam logic [7:0] ADDR_PASR_SEG   = 8'h11;
  localparam logic [7:0] ADDR_DQ_PAT_A   = 8'h20;
  localparam logic [7:0] ADDR_DQ_PAT_B   = 8'h28;
  localparam logic [7:0] ADDR_RESET_TRIG = 8'h3f;

  // Valid-bit masks; other positions are reserved_future_bits
  localparam logic [7:0] MASK_DEV_INFO  = 8'h1f;
  localparam logic [7:0] MASK_FEAT_TWO  = 8'h0f;
  localparam logic [7:0] MASK_IO_CFG    = 8'h0f;
  localparam logic [7:0] MASK_REFRESH   = 8'h87;
  localparam logic [7:0] MASK_FULL      = 8'hff;
  localparam int unsigned AUTO_INIT_BIT = 0;

  localparam logic [7:0] RST_FEAT_ONE  = 8'h22;
  localparam logic [7:0] RST_FEAT_TWO  = 8'h01;
  localparam logic [7:0] RST_IO_CFG    = 8'h02;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] UNDEF_DATA    = 8'h00;

  typedef enum logic [1:0] {
    SDMRF_ACC_NONE = 2'b00,
    SDMRF_ACC_RO   = 2'b01,
    SDMRF_ACC_WO   = 2'b10,
    SDMRF_ACC_RW   = 2'b11
  } sdmrf_acc_t;

  // Access class by address
  function automatic sdmrf_acc_t sdmrf_class(input logic [7:0] a);
    case (a)
      ADDR_DEV_INFO, ADDR_REFRESH, ADDR_MAKER, ADDR_REV_ONE,
      ADDR_REV_TWO, ADDR_WDT, ADDR_DQ_PAT_A,
      ADDR_DQ_PAT_B:   sdmrf_class = SDMRF_ACC_RO;
      ADDR_FEAT_ONE, ADDR_FEAT_TWO, ADDR_IO_CFG, ADDR_TEST_MODE,
      ADDR_IO_CAL, ADDR_PASR_BANK, ADDR_PASR_SEG,
      ADDR_RESET_TRIG: sdmrf_class = SDMRF_ACC_WO;
      default:         sdmrf_class = SDMRF_ACC_NONE;
    endcase
  endfunction

  function automatic logic [7:0] sdmrf_wmask(input logic [7:0] a);
    case (a)
      ADDR_FEAT_TWO: sdmrf_wmask = MASK_FEAT_TWO;
      ADDR_IO_CFG:   sdmrf_wmask = MASK_IO_CFG;
      default:       sdmrf_wmask = MASK_FULL;
    endcase
  endfunction
endpackage

// [src/sdmrf_if.sv]
`timescale 1ns/1ps
interface sdmrf_if;
  logic       cmd_valid;
  logic       cmd_write;
  logic [7:0] config_register_address;
  logic [7:0] wr_operand;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic       dqs_t;
  logic       dqs_c;

  modport device (
    input  cmd_valid, cmd_write, config_register_address, wr_operand,
    output rd_data, rd_valid, dqs_t, dqs_c
  );
  modport ctrl (
    output cmd_valid, cmd_write, config_register_address, wr_operand,
    input  rd_data, rd_valid, dqs_t, dqs_c
  );
endinterface

// [src/sdmrf_init_timer.sv]
`timescale 1ns/1ps
module sdmrf_init_timer
  import sdmrf_pkg::*;
#(
  parameter int unsigned COUNT = INIT_MAX_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy
);
  logic [31:0] cnt_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 32'h0;
    end else if (start) begin
      cnt_reg <= 32'(COUNT);
    end else if (cnt_reg != 32'h0) begin
      cnt_reg <= cnt_reg - 32'h1;
    end
  end

  assign busy = (cnt_reg != 32'h0);
endmodule // sdmrf_init_timer

// [src/sdmrf_device.sv]
`timescale 1ns/1ps
module sdmrf_device
  import sdmrf_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_MAX_CYCLES,
  parameter logic [7:0]  MAKER_ID    = 8'h5a, // Arbitrary value
  parameter logic [7:0]  REV_ONE_ID  = 8'h01, // Arbitrary value
  parameter logic [7:0]  REV_TWO_ID  = 8'h00, // Arbitrary value
  parameter logic [7:0]  WDT_VALUE   = 8'h00,
  parameter logic [7:0]  DQ_PAT_A    = 8'h00,
  parameter logic [7:0]  DQ_PAT_B    = 8'h00,
  parameter logic [7:0]  REFRESH_VAL = 8'h03
) (
  input  wire logic  mclk,
  input  wire logic  rst_n,
  sdmrf_if.device    bus,
  output logic [7:0] feature_one,
  output logic [7:0] feature_two,
  output logic [7:0] io_config,
  output logic [7:0] test_mode,
  output logic [7:0] io_cal_cmd,
  output logic [7:0] pasr_bank,
  output logic [7:0] pasr_seg,
  output logic       auto_init_status,
  output logic       io_cal_start
);
  logic [7:0]   feature_one_reg;
  logic [7:0]   feature_two_reg;
  logic [7:0]   io_config_reg;
  logic [7:0]   test_mode_reg;
  logic [7:0]   io_cal_reg;
  logic [7:0]   pasr_bank_reg;
  logic [7:0]   pasr_seg_reg;
  logic [7:0]   rd_data_reg;
  logic         rd_valid_reg;
  logic         dqs_reg;
  logic         io_cal_start_reg;
  logic         init_start_reg;
  logic         timer_busy;
  logic         wr_ok;
  logic         rd_cmd;
  logic [7:0]   rd_value;
  sdmrf_acc_t   acc;

  // Reset release also starts auto-init, as after power-up
  logic         por_pending_reg;

  assign acc    = sdmrf_class(bus.config_register_address);
  assign rd_cmd = bus.cmd_valid && !bus.cmd_write;
  // Only writable classes take the operand; read-only is dropped
  assign wr_ok  = bus.cmd_valid && bus.cmd_write &&
                  acc[1] && !timer_busy;

  // The start cycle already shows busy, so the timer runs one short;
  // the status then stays high for exactly INIT_CYCLES cycles
  sdmrf_init_timer #(
    .COUNT (INIT_CYCLES - 1)
  ) u_timer (
    .mclk  (mclk),
    .rst_n (rst_n),
    .start (init_start_reg),
    .busy  (timer_busy)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      por_pending_reg <= 1'b1;
      init_start_reg  <= 1'b0;
    end else begin
      por_pending_reg <= 1'b0;
      init_start_reg  <= por_pending_reg ||
        (bus.cmd_valid && bus.cmd_write &&
         bus.config_register_address == ADDR_RESET_TRIG);
    end
  end

  // Status high from the reset command until the timer expires
  assign auto_init_status = timer_busy || init_start_reg;

  // Mode configuration; auto-init returns it to defaults
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      feature_one_reg <= RST_FEAT_ONE;
      feature_two_reg <= RST_FEAT_TWO;
      io_config_reg   <= RST_IO_CFG;
    end else if (init_start_reg) begin
      feature_one_reg <= RST_FEAT_ONE;
      feature_two_reg <= RST_FEAT_TWO;
      io_config_reg   <= RST_IO_CFG;
    end else if (wr_ok) begin
      case (bus.config_register_address)
        ADDR_FEAT_ONE: feature_one_reg <= bus.wr_operand;
        // Masked again here so a careless controller cannot set them
        ADDR_FEAT_TWO: feature_two_reg <= bus.wr_operand &
                         sdmrf_wmask(ADDR_FEAT_TWO);
        ADDR_IO_CFG:   io_config_reg <= bus.wr_operand &
                         sdmrf_wmask(ADDR_IO_CFG);
        default:       ;
      endcase
    end
  end

  // Test mode and partial-array masks, cleared by auto-init
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      test_mode_reg <= RST_ZERO;
      pasr_bank_reg <= RST_ZERO;
      pasr_seg_reg  <= RST_ZERO;
    end else if (init_start_reg) begin
      test_mode_reg <= RST_ZERO;
      pasr_bank_reg <= RST_ZERO;
      pasr_seg_reg  <= RST_ZERO;
    end else if (wr_ok) begin
      case (bus.config_register_address)
        ADDR_TEST_MODE: test_mode_reg <= bus.wr_operand;
        ADDR_PASR_BANK: pasr_bank_reg <= bus.wr_operand;
        ADDR_PASR_SEG:  pasr_seg_reg  <= bus.wr_operand;
        default:        ;
      endcase
    end
  end

  // Calibration code survives auto-init: recalibrating costs time,
  // and the controller reissues it only when conditions change
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      io_cal_reg <= RST_ZERO;
    end else if (wr_ok && bus.config_register_address == ADDR_IO_CAL) begin
      io_cal_reg <= bus.wr_operand;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      io_cal_start_reg <= 1'b0;
    end else begin
      io_cal_start_reg <= wr_ok &&
        bus.config_register_address == ADDR_IO_CAL;
    end
  end

  // Read mux; reserved bits masked to zero
  always_comb begin
    rd_value = UNDEF_DATA;
    case (bus.config_register_address)
      ADDR_DEV_INFO: begin
        rd_value = RST_ZERO;
        rd_value[AUTO_INIT_BIT] = auto_init_status;
        rd_value = rd_value & MASK_DEV_INFO;
      end
      ADDR_REFRESH:  rd_value = REFRESH_VAL & MASK_REFRESH;
      ADDR_MAKER:    rd_value = MAKER_ID;
      ADDR_REV_ONE:  rd_value = REV_ONE_ID;
      ADDR_REV_TWO:  rd_value = REV_TWO_ID;
      ADDR_WDT:      rd_value = WDT_VALUE;
      ADDR_DQ_PAT_A: rd_value = DQ_PAT_A;
      ADDR_DQ_PAT_B: rd_value = DQ_PAT_B;
      default:       rd_value = UNDEF_DATA;
    endcase
  end

  // Every read answers with strobe toggle, whatever its class
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg  <= RST_ZERO;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_cmd;
      if (rd_cmd) begin
        rd_data_reg <= rd_value;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dqs_reg <= 1'b0;
    end else if (rd_cmd) begin
      dqs_reg <= !dqs_reg;
    end
  end

  assign bus.rd_data  = rd_data_reg;
  assign bus.rd_valid = rd_valid_reg;
  assign bus.dqs_t    = dqs_reg;
  assign bus.dqs_c    = !dqs_reg;

  assign feature_one  = feature_one_reg;
  assign feature_two  = feature_two_reg;
  assign io_config    = io_config_reg;
  assign test_mode    = test_mode_reg;
  assign io_cal_cmd   = io_cal_reg;
  assign pasr_bank    = pasr_bank_reg;
  assign pasr_seg     = pasr_seg_reg;
  assign io_cal_start = io_cal_start_reg;
endmodule // sdmrf_device

// [src/sdmrf_ctrl.sv]
`timescale 1ns/1ps
module sdmrf_ctrl
  import sdmrf_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_MAX_CYCLES
) (
  input  wire logic  mclk,
  input  wire logic  rst_n,
  sdmrf_if.ctrl      bus,
  input  wire logic  req_valid,
  input  wire logic  req_write,
  input  wire logic [7:0] req_addr,
  input  wire logic [7:0] req_data,
  output logic       req_ready,
  output logic [7:0] resp_data,
  output logic       resp_valid,
  output logic       req_refused,
  output logic       init_done
);
  typedef enum logic [3:0] {
    SDMRF_IDLE = 4'b0001,
    SDMRF_WAIT = 4'b0010,
    SDMRF_POLL = 4'b0100,
    SDMRF_RDWT = 4'b1000
  } sdmrf_state_t;

  sdmrf_state_t state_reg;
  logic [31:0]  wait_reg;
  logic         cmd_valid_reg;
  logic         cmd_write_reg;
  logic [7:0]   addr_reg;
  logic [7:0]   data_reg;
  logic [7:0]   resp_data_reg;
  logic         resp_valid_reg;
  logic         refused_reg;
  logic         polling_reg;
  logic         done_reg;
  logic         legal;

  // Writes to reserved targets are refused before reaching the bus; reads of them still go out
  assign legal = !req_write || sdmrf_class(req_addr) != SDMRF_ACC_NONE;
  assign req_ready = (state_reg == SDMRF_IDLE) && done_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= SDMRF_WAIT;
      wait_reg      <= 32'(INIT_CYCLES);
      cmd_valid_reg <= 1'b0;
      cmd_write_reg <= 1'b0;
      addr_reg      <= RST_ZERO;
      data_reg      <= RST_ZERO;
      refused_reg   <= 1'b0;
      polling_reg   <= 1'b0;
      done_reg      <= 1'b0;
    end else begin
      cmd_valid_reg <= 1'b0;
      refused_reg   <= 1'b0;
      case (state_reg)
        SDMRF_IDLE: begin
          if (req_valid && done_reg) begin
            if (!legal) begin
              refused_reg <= 1'b1;
            end else begin
              cmd_valid_reg <= 1'b1;
              cmd_write_reg <= req_write;
              addr_reg      <= req_addr;
              // Reserved bits always driven zero
              data_reg <= req_data & sdmrf_wmask(req_addr);
              polling_reg <= 1'b0;
              if (req_write && req_addr == ADDR_RESET_TRIG) begin
                state_reg <= SDMRF_WAIT;
                wait_reg  <= 32'(INIT_CYCLES);
                done_reg  <= 1'b0;
              end else if (!req_write) begin
                state_reg <= SDMRF_RDWT;
              end
            end
          end
        end
        SDMRF_WAIT: begin
          if (wait_reg == 32'h0) begin
            state_reg <= SDMRF_IDLE;
            done_reg  <= 1'b1;
          end else begin
            wait_reg      <= wait_reg - 32'h1;
            cmd_valid_reg <= 1'b1;
            cmd_write_reg <= 1'b0;
            addr_reg      <= ADDR_DEV_INFO;
            polling_reg   <= 1'b1;
            state_reg     <= SDMRF_POLL;
          end
        end
        SDMRF_POLL: begin
          if (wait_reg != 32'h0) begin
            wait_reg <= wait_reg - 32'h1;
          end
          if (bus.rd_valid) begin
            if (!bus.rd_data[AUTO_INIT_BIT]) begin
              state_reg <= SDMRF_IDLE;
              done_reg  <= 1'b1;
            end else begin
              state_reg <= SDMRF_WAIT;
            end
          end
        end
        SDMRF_RDWT: begin
          if (bus.rd_valid) begin
            state_reg <= SDMRF_IDLE;
          end
        end
        default: state_reg <= SDMRF_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      resp_data_reg  <= RST_ZERO;
      resp_valid_reg <= 1'b0;
    end else begin
      resp_valid_reg <= bus.rd_valid && !polling_reg;
      if (bus.rd_valid && !polling_reg) begin
        resp_data_reg <= bus.rd_data;
      end
    end
  end

  assign bus.cmd_valid               = cmd_valid_reg;
  assign bus.cmd_write               = cmd_write_reg;
  assign bus.config_register_address = addr_reg;
  assign bus.wr_operand              = data_reg;
  assign resp_data   = resp_data_reg;
  assign resp_valid  = resp_valid_reg;
  assign req_refused = refused_reg;
  assign init_done   = done_reg;
endmodule // sdmrf_ctrl

// [verif/sdmrf_properties.sv]
`timescale 1ns/1ps
module sdmrf_properties
  import sdmrf_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       cmd_valid,
  input wire logic       cmd_write,
  input wire logic [7:0] config_register_address,
  input wire logic [7:0] wr_operand,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid,
  input wire logic       dqs_t,
  input wire logic       dqs_c
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  function automatic logic is_ro(input logic [7:0] a);
    return a inside {ADDR_DEV_INFO, ADDR_REFRESH, ADDR_MAKER, ADDR_REV_ONE,
                     ADDR_REV_TWO, ADDR_WDT, ADDR_DQ_PAT_A, ADDR_DQ_PAT_B};
  endfunction
  function automatic logic is_wo(input logic [7:0] a);
    return a inside {ADDR_FEAT_ONE, ADDR_FEAT_TWO, ADDR_IO_CFG,
                     ADDR_TEST_MODE, ADDR_IO_CAL, ADDR_PASR_BANK,
                     ADDR_PASR_SEG, ADDR_RESET_TRIG};
  endfunction
  function automatic logic [7:0] rmask(input logic [7:0] a);
    return (a == ADDR_DEV_INFO) ? MASK_DEV_INFO :
           (a == ADDR_REFRESH) ? MASK_REFRESH : MASK_FULL;
  endfunction
  function automatic logic [7:0] wmask(input logic [7:0] a);
    return (a == ADDR_FEAT_TWO) ? MASK_FEAT_TWO :
           (a == ADDR_IO_CFG) ? MASK_IO_CFG : MASK_FULL;
  endfunction

  property p_rd_answer;
    cmd_valid && !cmd_write |=> rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read command got no answer");
  property p_rd_cause;
    rd_valid |-> $past(cmd_valid) && !$past(cmd_write);
  endproperty
  a_rd_cause: assert property (p_rd_cause)
    else $error("read answer without read command");
  property p_one_read;
    cmd_valid && !cmd_write |=> !cmd_valid;
  endproperty
  a_one_read: assert property (p_one_read)
    else $error("command issued while a read is pending");
  property p_dqs_toggle;
    cmd_valid && !cmd_write |=> dqs_t != $past(dqs_t);
  endproperty
  a_dqs_toggle: assert property (p_dqs_toggle)
    else $error("strobe did not toggle on read");
  property p_dqs_quiet;
    !(cmd_valid && !cmd_write) |=> $stable(dqs_t);
  endproperty
  a_dqs_quiet: assert property (p_dqs_quiet)
    else $error("strobe moved without read");
  property p_dqs_pair;
    dqs_t != dqs_c;
  endproperty
  a_dqs_pair: assert property (p_dqs_pair)
    else $error("strobe pair not complementary");
  property p_rfu_read;
    rd_valid |-> (rd_data & ~rmask($past(config_register_address))) == 8'h00;
  endproperty
  a_rfu_read: assert property (p_rfu_read)
    else $error("reserved read bits not zero");
  property p_undef_read;
    rd_valid && !is_ro($past(config_register_address)) |->
      rd_data == UNDEF_DATA;
  endproperty
  a_undef_read: assert property (p_undef_read)
    else $error("unreadable address returned data");
  property p_no_rsvd_write;
    cmd_valid && cmd_write |->
      is_ro(config_register_address) || is_wo(config_register_address);
  endproperty
  a_no_rsvd_write: assert property (p_no_rsvd_write)
    else $error("write sent to reserved address");
  property p_rfu_write;
    cmd_valid && cmd_write |->
      (wr_operand & ~wmask(config_register_address)) == 8'h00;
  endproperty
  a_rfu_write: assert property (p_rfu_write)
    else $error("reserved operand bits not zero");
endmodule // sdmrf_properties

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import sdmrf_pkg::*;
  localparam int unsigned INIT_SIM = 20;
  localparam logic [7:0] WO [7] = '{ADDR_FEAT_ONE, ADDR_FEAT_TWO,
    ADDR_IO_CFG, ADDR_TEST_MODE, ADDR_IO_CAL, ADDR_PASR_BANK, ADDR_PASR_SEG};
  localparam logic [7:0] RO [8] = '{ADDR_DEV_INFO, ADDR_REFRESH, ADDR_MAKER,
    ADDR_REV_ONE, ADDR_REV_TWO, ADDR_WDT, ADDR_DQ_PAT_A, ADDR_DQ_PAT_B};
  // Dev info keeps only status and reserved bits comparable
  localparam logic [7:0] RO_EXP [8] = '{8'h00, 8'h83, 8'h5a, 8'h01,
    8'h07, 8'h18, 8'h55, 8'haa};
  localparam logic [7:0] RSV [8] = '{8'h0b, 8'h12, 8'h14, 8'h21, 8'h30,
    8'h7f, 8'h80, 8'hff};
  logic       mclk;
  logic       rst_n;
  logic       req_valid;
  logic       req_write;
  logic [7:0] req_addr;
  logic [7:0] req_data;
  logic       req_ready;
  logic [7:0] resp_data;
  logic       resp_valid;
  logic       req_refused;
  logic       init_done;
  logic [7:0] outs [7];
  logic       auto_init_status;
  logic       io_cal_start;
  logic [7:0] got;
  logic       refused;
  logic       cal_seen;
  logic [7:0] d;
  int         mdl [7];
  int         num_errors;
  int         checked;
  int         n;

  sdmrf_if bus_if ();
  sdmrf_device #(.INIT_CYCLES(INIT_SIM),
    .REV_TWO_ID(8'h07), .WDT_VALUE(8'h18),
    .DQ_PAT_A(8'h55), .DQ_PAT_B(8'haa), .REFRESH_VAL(8'hfb)
  ) sdmrf_device_inst (.mclk(mclk), .rst_n(rst_n), .bus(bus_if),
    .feature_one(outs[0]), .feature_two(outs[1]), .io_config(outs[2]),
    .test_mode(outs[3]), .io_cal_cmd(outs[4]), .pasr_bank(outs[5]),
    .pasr_seg(outs[6]), .auto_init_status(auto_init_status),
    .io_cal_start(io_cal_start));
  sdmrf_ctrl #(.INIT_CYCLES(INIT_SIM)) sdmrf_ctrl_inst (.mclk(mclk),
    .rst_n(rst_n), .bus(bus_if), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_data(req_data),
    .req_ready(req_ready), .resp_data(resp_data), .resp_valid(resp_valid),
    .req_refused(req_refused), .init_done(init_done));
  sdmrf_properties sdmrf_properties_inst (.mclk(mclk), .rst_n(rst_n),
    .cmd_valid(bus_if.cmd_valid), .cmd_write(bus_if.cmd_write),
    .config_register_address(bus_if.config_register_address),
    .wr_operand(bus_if.wr_operand), .rd_data(bus_if.rd_data),
    .rd_valid(bus_if.rd_valid), .dqs_t(bus_if.dqs_t), .dqs_c(bus_if.dqs_c));

  always #2.5 mclk = ~mclk;

  task automatic check_byte(input string what, input logic [7:0] exp,
                            input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic check_bit(input string what, input logic exp,
                           input logic seen);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %b seen %b", what, exp, seen);
    end
  endtask
  // Auto-init leaves the calibration code alone
  task automatic reset_model(input logic keep_cal);
    mdl = '{'h22, 'h01, 'h02, 0, keep_cal ? mdl[4] : 0, 0, 0};
  endtask
  task automatic check_outs();
    for (int i = 0; i < 7; i++) begin
      check_byte("config output", mdl[i][7:0], outs[i]);
    end
  endtask
  // Request raised for one edge once req_ready is seen; answers gathered over the next four edges
  task automatic do_req(input logic wr, input logic [7:0] a,
                        input logic [7:0] dat);
    n = 0;
    while (req_ready !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check_bit("req_ready", 1'b1, req_ready);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_data = dat;
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    got = 8'hxx;
    // The refusal pulse stands only in the cycle after the request edge
    refused = (req_refused === 1'b1);
    cal_seen = 1'b0;
    repeat (4) begin
      @(posedge mclk);
      #1;
      if (resp_valid === 1'b1) got = resp_data;
      refused |= (req_refused === 1'b1);
      cal_seen |= (io_cal_start === 1'b1);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    $display("unexpected watchdog: expected end seen hang");
    report_and_stop();
  end

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 8'h00;
    req_data = 8'h00;
    num_errors = 0;
    checked = 0;
    d = 8'($urandom(32'hc647));
    reset_model(1'b0);
    repeat (12) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      do_req(1'b0, RO[i], 8'h00);
      if (i == 0) got &= 8'he1;
      check_byte("ro read", RO_EXP[i], got);
    end
    check_bit("init_done", 1'b1, init_done);
    check_outs();
    $display("test readable done");
    for (int i = 0; i < 7; i++) begin
      d = 8'($urandom);
      do_req(1'b1, WO[i], d);
      mdl[i] = d & (i == 1 ? MASK_FEAT_TWO : i == 2 ? MASK_IO_CFG : 8'hff);
      check_bit("refused", 1'b0, refused);
      check_bit("cal pulse", WO[i] == ADDR_IO_CAL, cal_seen);
      check_outs();
      do_req(1'b0, WO[i], 8'h00);
      check_byte("wo read", UNDEF_DATA, got);
    end
    $display("test writable done");
    for (int i = 0; i < 8; i++) begin
      do_req(1'b1, RO[i], 8'($urandom));
      check_outs();
      do_req(1'b0, RO[i], 8'h00);
      if (i == 0) got &= 8'he1;
      check_byte("ro after write", RO_EXP[i], got);
    end
    $display("test read-only done");
    for (int i = 0; i < 8; i++) begin
      do_req(1'b1, RSV[i], 8'($urandom));
      check_bit("refused", 1'b1, refused);
      do_req(1'b0, RSV[i], 8'h00);
      check_byte("rsvd read", UNDEF_DATA, got);
    end
    check_outs();
    $display("test reserved done");
    do_req(1'b1, ADDR_RESET_TRIG, 8'h00);
    check_bit("auto_init_status", 1'b1, auto_init_status);
    n = 0;
    while (auto_init_status === 1'b1 && n < INIT_SIM + 8) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check_bit("auto_init_status", 1'b0, auto_init_status);
    reset_model(1'b1);
    check_outs();
    do_req(1'b0, ADDR_DEV_INFO, 8'h00);
    check_byte("status read", 8'h00, got & 8'he1);
    $display("test reinit done");
    report_and_stop();
  end
endmodule // testbench
